// *** verilog/irs_device.sv ***
// Device end: register read slave on the push-pull module link.
// Assumes link_clock_in oversamples SCL/SDA; register data comes on clock_in.
`timescale 1ns/100ps
`include "irs_map.svh"
module irs_device
   import irs_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       reset_in,
   input  wire logic       link_clock_in,
   irs_link_if.device      link,
   input  wire logic [1:0] addr_nv_bits_in,
   input  wire logic       addr_use_pin_in,
   input  wire logic       addr_pin_in,
   input  wire logic       sam_addr_load_in,
   input  wire logic [6:0] sam_addr_nv_in,
   input  wire logic [7:0] rd_data_in,
   output logic      [7:0] rd_addr_out,
   output logic            rd_strobe_out,
   output logic      [6:0] sam_addr_out
);
   irs_dev_state_t state;
   logic       rst_meta, link_rst;
   logic       scl_meta, scl_s, scl_d;
   logic       sda_meta, sda_s, sda_d;
   logic [3:0] cfg_meta, cfg_s, bit_cnt;
   logic [6:0] own_addr;
   logic       rise, fall, start_ev, stop_ev, byte_done, addr_match;
   logic       drive_now, drive_val, fetch_now, read_dir;
   logic [2:0] drv_cnt;
   logic       sda_out, sda_oe_n, keep;
   logic [7:0] ptr, fetch_addr, fetched, shift, data_hold;
   logic       req_tgl, ack_meta, ack_s, ack_seen, ack_tgl;
   logic       req_meta, req_s, req_seen, strobe_d;
   // ==========================================================
   // Link side synchronisers
   always_ff @(posedge link_clock_in) begin
      rst_meta <= reset_in;
      link_rst <= rst_meta;
   end
   // SCL is only ever sampled here, never driven or held
   always_ff @(posedge link_clock_in) begin
      if (link_rst) begin
         scl_meta <= 1'b1;
         scl_s    <= 1'b1;
         scl_d    <= 1'b1;
         sda_meta <= 1'b1;
         sda_s    <= 1'b1;
         sda_d    <= 1'b1;
         cfg_meta <= 4'h0;
         cfg_s    <= 4'h0;
      end else begin
         scl_meta <= link.module_clock_pin;
         scl_s    <= scl_meta;
         scl_d    <= scl_s;
         sda_meta <= link.module_data_in_pin;
         sda_s    <= sda_meta;
         sda_d    <= sda_s;
         cfg_meta <= {addr_use_pin_in, addr_pin_in, addr_nv_bits_in};
         cfg_s    <= cfg_meta;
      end
   end
   assign rise     = scl_s && !scl_d;
   assign fall     = !scl_s && scl_d;
   assign start_ev = scl_s && scl_d && sda_d && !sda_s;
   assign stop_ev  = scl_s && scl_d && !sda_d && sda_s;
   // Pin option pins the upper selectable bit to zero
   assign own_addr   = {`IRS_ADDR_HIGH, cfg_s[3] ? {1'b0, cfg_s[2]} : cfg_s[1:0]};
   assign addr_match = (shift[7:1] == own_addr);
   // ==========================================================
   // Bit and byte decisions
   always_comb begin
      byte_done = fall && (bit_cnt == 4'h8);
      drive_now = 1'b0;
      drive_val = 1'b0;
      fetch_now = 1'b0;
      case (state)
         DEV_ADDR: begin
            drive_now = byte_done && addr_match;
            fetch_now = byte_done && addr_match && shift[0];
         end
         DEV_REG: drive_now = byte_done;
         DEV_ADDR_ACK: begin
            drive_now = fall && read_dir;
            drive_val = fetched[7];
         end
         DEV_TX: begin
            drive_now = fall && (bit_cnt != 4'h8);
            drive_val = shift[7];
         end
         DEV_TX_ACK: fetch_now = rise && !sda_s;
         DEV_TX_WAIT: begin
            drive_now = fall;
            drive_val = fetched[7];
         end
         default: drive_now = 1'b0;
      endcase
   end
   // ==========================================================
   // Frame state machine
   always_ff @(posedge link_clock_in) begin
      if (link_rst) begin
         state    <= DEV_IDLE;
         bit_cnt  <= 4'h0;
         shift    <= 8'h00;
         read_dir <= 1'b0;
      end else if (start_ev) begin
         state   <= DEV_ADDR;
         bit_cnt <= 4'h0;
      end else if (stop_ev) begin
         state <= DEV_IDLE;
      end else begin
         case (state)
            DEV_ADDR, DEV_REG, DEV_WDATA: begin
               if (rise) begin
                  shift   <= {shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  bit_cnt <= 4'h0;
                  if (state == DEV_ADDR) begin
                     read_dir <= shift[0];
                     state    <= addr_match ? DEV_ADDR_ACK : DEV_IDLE;
                  end else if (state == DEV_REG) begin
                     state <= DEV_REG_ACK;
                  end else begin
                     state <= DEV_IDLE;  // Extra write data is not acknowledged
                  end
               end
            end
            DEV_ADDR_ACK: begin
               if (fall && read_dir) begin
                  shift   <= {fetched[6:0], 1'b0};
                  bit_cnt <= 4'h1;
                  state   <= DEV_TX;
               end else if (fall) begin
                  state <= DEV_REG;
               end
            end
            DEV_REG_ACK: state <= fall ? DEV_WDATA : DEV_REG_ACK;
            DEV_TX: begin
               if (fall && (bit_cnt == 4'h8)) begin
                  state <= DEV_TX_ACK;
               end else if (fall) begin
                  shift   <= {shift[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            DEV_TX_ACK: begin
               if (rise) begin
                  state <= sda_s ? DEV_IDLE : DEV_TX_WAIT;
               end
            end
            DEV_TX_WAIT: begin
               if (fall) begin
                  shift   <= {fetched[6:0], 1'b0};
                  bit_cnt <= 4'h1;
                  state   <= DEV_TX;
               end
            end
            default: state <= DEV_IDLE;
         endcase
      end
   end
   // ==========================================================
   // SDA driver: drive only a short window after SCL falls, so the
   // line is released well before the master raises SCL again
   always_ff @(posedge link_clock_in) begin
      if (link_rst || start_ev || stop_ev) begin
         sda_out  <= 1'b1;
         sda_oe_n <= 1'b1;
         drv_cnt  <= 3'h0;
      end else if (drive_now) begin
         sda_out  <= drive_val;
         sda_oe_n <= 1'b0;
         drv_cnt  <= 3'(`IRS_DRIVE_CYC);
      end else if (drv_cnt != 3'h0) begin
         drv_cnt <= drv_cnt - 3'h1;
         if (drv_cnt == 3'h1) begin
            sda_oe_n <= 1'b1;
         end
      end
   end
   // Keeper follows the line so an undriven SDA holds its last level
   always_ff @(posedge link_clock_in) begin
      if (link_rst) begin
         keep <= 1'b1;
      end else begin
         keep <= sda_s;
      end
   end
   assign link.dev_sda_out  = sda_out;
   assign link.dev_sda_oe_n = sda_oe_n;
   assign link.dev_sda_keep = keep;
   // ==========================================================
   // Register pointer and fetch request
   always_ff @(posedge link_clock_in) begin
      if (link_rst) begin
         ptr        <= 8'h00;
         fetch_addr <= 8'h00;
         req_tgl    <= 1'b0;
      end else if ((state == DEV_REG) && byte_done) begin
         ptr <= shift;                          // Survives stop and restart
      end else if (fetch_now) begin
         fetch_addr <= ptr;
         req_tgl    <= !req_tgl;
         ptr        <= (ptr == `IRS_FIFO_ADDR) ? ptr : ptr + 8'h01;
      end
   end
   always_ff @(posedge link_clock_in) begin
      if (link_rst) begin
         ack_meta <= 1'b0;
         ack_s    <= 1'b0;
         ack_seen <= 1'b0;
         fetched  <= 8'h00;
      end else begin
         ack_meta <= ack_tgl;
         ack_s    <= ack_meta;
         ack_seen <= ack_s;
         if (ack_s != ack_seen) begin
            fetched <= data_hold;  // Held stable since the toggle
         end
      end
   end
   // ==========================================================
   // Register side: toggle handshake, fetch_addr is stable meanwhile
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         req_meta      <= 1'b0;
         req_s         <= 1'b0;
         req_seen      <= 1'b0;
         rd_strobe_out <= 1'b0;
         rd_addr_out   <= 8'h00;
      end else begin
         req_meta      <= req_tgl;
         req_s         <= req_meta;
         req_seen      <= req_s;
         rd_strobe_out <= (req_s != req_seen);
         if (req_s != req_seen) begin
            rd_addr_out <= fetch_addr;
         end
      end
   end
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         strobe_d  <= 1'b0;
         ack_tgl   <= 1'b0;
         data_hold <= 8'h00;
      end else begin
         strobe_d <= rd_strobe_out;
         if (rd_strobe_out) begin
            data_hold <= rd_data_in;
         end
         if (strobe_d) begin
            ack_tgl <= !ack_tgl;
         end
      end
   end
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         sam_addr_out <= `IRS_SAM_ADDR_RST;
      end else if (sam_addr_load_in) begin
         sam_addr_out <= sam_addr_nv_in;
      end
   end
endmodule // irs_device

// *** verilog/irs_map.svh ***
// Constants of the register read slave and its push-pull module link.
// Assumes a 100 MHz clock_in and an 80 ns link clock at the device end.
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH

// ==========================================================
// Addresses and codes
`define IRS_ADDR_HIGH     5'h0a
`define IRS_SAM_ADDR_RST  7'h2c
`define IRS_FIFO_ADDR     8'h05
`define IRS_RW_WRITE      1'h0
`define IRS_RW_READ       1'h1

// ==========================================================
// Timing
`define IRS_CLK_MHZ       100
`define IRS_SCL_MAX_KHZ   5000
`define IRS_QUARTER_NS    500
`define IRS_QUARTER_CYC   ((`IRS_QUARTER_NS * `IRS_CLK_MHZ) / 1000)
`define IRS_LINK_NS       80
`define IRS_DRIVE_NS      320
`define IRS_DRIVE_CYC     (`IRS_DRIVE_NS / `IRS_LINK_NS)

`endif

// *** verilog/irs_pkg.sv ***
// Types shared by both ends of the module link.
// Assumes irs_map.svh carries all numbers.
package irs_pkg;
   typedef enum logic [3:0] {
      DEV_IDLE, DEV_ADDR, DEV_ADDR_ACK, DEV_REG, DEV_REG_ACK,
      DEV_WDATA, DEV_TX, DEV_TX_ACK, DEV_TX_WAIT
   } irs_dev_state_t;

   typedef enum logic [2:0] {
      HST_IDLE, HST_START, HST_TXB, HST_RXACK, HST_RSTART, HST_RXB, HST_TXACK, HST_STOP
   } irs_host_state_t;

   typedef enum logic [1:0] {
      HOP_ADDR_WR, HOP_REG, HOP_ADDR_RD
   } irs_host_step_t;
endpackage

// *** verilog/irs_link_if.sv ***
// Push-pull module link between master and device end.
// Assumes exactly one master and one device; the bench joins them here.
`timescale 1ns/100ps
interface irs_link_if;
   logic module_clock_pin;    // SCL, push-pull from the master
   logic host_sda_out;
   logic host_sda_oe_n;
   logic dev_sda_out;
   logic dev_sda_oe_n;
   logic dev_sda_keep;        // Keeper level from the device
   logic module_data_in_pin;  // Resolved SDA

   // ==========================================================
   // Line resolution: one master, one slave, no wired-and
   assign module_data_in_pin = !host_sda_oe_n ? host_sda_out :
                               !dev_sda_oe_n  ? dev_sda_out  : dev_sda_keep;

   modport host   (output module_clock_pin, host_sda_out, host_sda_oe_n,
                   input  module_data_in_pin);
   modport device (input  module_clock_pin, module_data_in_pin,
                   output dev_sda_out, dev_sda_oe_n, dev_sda_keep);
endinterface

// *** verilog/irs_host.sv ***
// Master end of the push-pull module link: address write, then read.
// Assumes a single device on the link; SCL comes from a clock_in divider.
`timescale 1ns/100ps
`include "irs_map.svh"
module irs_host
   import irs_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       reset_in,
   irs_link_if.host        link,
   input  wire logic       cmd_start_in,
   input  wire logic [6:0] cmd_dev_addr_in,
   input  wire logic [7:0] cmd_reg_in,
   input  wire logic [7:0] cmd_count_in,
   output logic            busy_out,
   output logic      [7:0] rd_data_out,
   output logic            rd_valid_out,
   output logic            nack_out,
   output logic            done_out
);
   irs_host_state_t state;
   irs_host_step_t  step;
   logic [5:0] q_cnt;
   logic       tick;
   logic [1:0] phase;
   logic [2:0] bits;
   logic [7:0] tx_byte, rx_byte, remaining, reg_addr;
   logic [6:0] dev_addr;
   logic       ack_bit, scl, sda, sda_oe_n;
   logic       sda_meta, sda_s;

   // ==========================================================
   // Quarter-bit divider; four quarters of 500 ns keep SCL well under 5 MHz
   assign tick = (q_cnt == 6'(`IRS_QUARTER_CYC - 1));

   always_ff @(posedge clock_in) begin
      if (reset_in || (state == HST_IDLE) || tick) begin
         q_cnt <= 6'h00;
      end else begin
         q_cnt <= q_cnt + 6'h01;
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         sda_meta <= 1'b1;
         sda_s    <= 1'b1;
      end else begin
         sda_meta <= link.module_data_in_pin;
         sda_s    <= sda_meta;
      end
   end

   assign link.module_clock_pin = scl;
   assign link.host_sda_out     = sda;
   assign link.host_sda_oe_n    = sda_oe_n;

   // ==========================================================
   // Frame sequencer; actions happen at the end of each quarter
   always_ff @(posedge clock_in) begin
      rd_valid_out <= 1'b0;
      done_out     <= 1'b0;
      if (reset_in) begin
         state     <= HST_IDLE;
         step      <= HOP_ADDR_WR;
         phase     <= 2'h0;
         bits      <= 3'h0;
         scl       <= 1'b1;
         sda       <= 1'b1;
         sda_oe_n  <= 1'b0;
         busy_out  <= 1'b0;
         nack_out  <= 1'b0;
         ack_bit   <= 1'b0;
         tx_byte   <= 8'h00;
         rx_byte   <= 8'h00;
         remaining <= 8'h00;
         reg_addr  <= 8'h00;
         dev_addr  <= 7'h00;
         rd_data_out <= 8'h00;
      end else if (state == HST_IDLE) begin
         scl      <= 1'b1;
         sda      <= 1'b1;
         sda_oe_n <= 1'b0;
         phase    <= 2'h0;
         if (cmd_start_in) begin
            busy_out  <= 1'b1;
            nack_out  <= 1'b0;
            dev_addr  <= cmd_dev_addr_in;
            reg_addr  <= cmd_reg_in;
            remaining <= (cmd_count_in == 8'h00) ? 8'h01 : cmd_count_in;
            tx_byte   <= {cmd_dev_addr_in, `IRS_RW_WRITE};
            step      <= HOP_ADDR_WR;
            state     <= HST_START;
         end
      end else if (tick) begin
         phase <= phase + 2'h1;
         case (state)
            HST_START, HST_RSTART: begin
               if ((state == HST_RSTART) && (phase == 2'h0)) begin
                  scl <= 1'b1;
               end else if (phase == 2'h1) begin
                  sda <= 1'b0;   // Start while SCL is high
               end else if (phase == 2'h2) begin
                  scl <= 1'b0;
               end else if (phase == 2'h3) begin
                  sda   <= tx_byte[7];
                  state <= HST_TXB;
                  bits  <= 3'h0;
               end
            end
            HST_TXB: begin
               if (phase == 2'h0) begin
                  sda_oe_n <= 1'b1;  // Keeper holds the bit while SCL is high
               end else if (phase == 2'h1) begin
                  scl <= 1'b1;
               end else if (phase == 2'h3) begin
                  scl  <= 1'b0;
                  bits <= bits + 3'h1;
                  if (bits == 3'h7) begin
                     state <= HST_RXACK;
                  end else begin
                     tx_byte  <= {tx_byte[6:0], 1'b0};
                     sda      <= tx_byte[6];
                     sda_oe_n <= 1'b0;
                  end
               end
            end
            HST_RXACK: begin
               if (phase == 2'h1) begin
                  scl <= 1'b1;
               end else if (phase == 2'h2) begin
                  ack_bit <= sda_s;
               end else if (phase == 2'h3) begin
                  scl <= 1'b0;
                  if (ack_bit) begin
                     nack_out <= 1'b1;
                     sda      <= 1'b0;
                     sda_oe_n <= 1'b0;
                     state    <= HST_STOP;
                  end else if (step == HOP_ADDR_WR) begin
                     step     <= HOP_REG;
                     tx_byte  <= reg_addr;
                     sda      <= reg_addr[7];
                     sda_oe_n <= 1'b0;
                     state    <= HST_TXB;
                     bits     <= 3'h0;
                  end else if (step == HOP_REG) begin
                     step     <= HOP_ADDR_RD;
                     tx_byte  <= {dev_addr, `IRS_RW_READ};
                     sda      <= 1'b1;
                     sda_oe_n <= 1'b0;
                     state    <= HST_RSTART;
                  end else begin
                     state <= HST_RXB;
                     bits  <= 3'h0;
                  end
               end
            end
            HST_RXB: begin
               if (phase == 2'h1) begin
                  scl <= 1'b1;
               end else if (phase == 2'h2) begin
                  rx_byte <= {rx_byte[6:0], sda_s};
               end else if (phase == 2'h3) begin
                  scl  <= 1'b0;
                  bits <= bits + 3'h1;
                  if (bits == 3'h7) begin
                     rd_data_out  <= rx_byte;
                     rd_valid_out <= 1'b1;
                     sda          <= (remaining == 8'h01);
                     sda_oe_n     <= 1'b0;
                     state        <= HST_TXACK;
                  end
               end
            end
            HST_TXACK: begin
               if (phase == 2'h0) begin
                  sda_oe_n <= 1'b1;
               end else if (phase == 2'h1) begin
                  scl <= 1'b1;
               end else if (phase == 2'h3) begin
                  scl <= 1'b0;
                  if (remaining == 8'h01) begin
                     sda      <= 1'b0;
                     sda_oe_n <= 1'b0;
                     state    <= HST_STOP;
                  end else begin
                     remaining <= remaining - 8'h01;
                     bits      <= 3'h0;
                     state     <= HST_RXB;
                  end
               end
            end
            HST_STOP: begin
               if (phase == 2'h0) begin
                  scl <= 1'b1;
               end else if (phase == 2'h1) begin
                  sda <= 1'b1;   // Stop while SCL is high
               end else if (phase == 2'h3) begin
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
                  state    <= HST_IDLE;
               end
            end
            default: begin
               state <= HST_IDLE;
            end
         endcase
      end
   end
endmodule // irs_host

// *** verif/irs_link_assertions.sv ***
// Checker of the module link wires between the host and device ends.
// Assumes clock_in oversamples the link; sits beside the interface.
`timescale 1ns/100ps
module irs_link_assertions (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic module_clock_pin,
   input wire logic host_sda_out,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_out,
   input wire logic dev_sda_oe_n,
   input wire logic dev_sda_keep,
   input wire logic module_data_in_pin
);
   // ==========================================================
   // Wire rules, sampled at 100 MHz
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   a_single_sda_driver: assert property (host_sda_oe_n || dev_sda_oe_n)
      else $error("both ends drive sda");
   a_quiet_scl_high: assert property (module_clock_pin |-> dev_sda_oe_n)
      else $error("device drives sda while scl high");
   a_keep_host_level: assert property (($rose(host_sda_oe_n) && dev_sda_oe_n)
      |-> dev_sda_keep == $past(host_sda_out)) else $error("keeper lost host level");
   a_keep_dev_level: assert property (($rose(dev_sda_oe_n) && host_sda_oe_n)
      |-> dev_sda_keep == $past(dev_sda_out)) else $error("keeper lost device level");
   // Drive lasts four link clocks, so the release must come well inside the low phase
   a_dev_drive_window: assert property ($fell(dev_sda_oe_n)
      |-> !dev_sda_oe_n [*8] ##[1:40] dev_sda_oe_n) else $error("device drive window wrong");
   a_sda_stable_high: assert property ((module_clock_pin && $past(module_clock_pin)
      && host_sda_oe_n) |-> $stable(module_data_in_pin)) else $error("sda moved in scl high");
   a_scl_high_min: assert property ($rose(module_clock_pin)
      |-> module_clock_pin [*8] ##1 module_clock_pin ##1 module_clock_pin) else $error("scl high short");
   a_scl_low_min: assert property ($fell(module_clock_pin)
      |-> !module_clock_pin [*8] ##1 !module_clock_pin ##1 !module_clock_pin) else $error("scl low short");
   c_dev_drive: cover property ($fell(dev_sda_oe_n));
   c_host_release: cover property ($rose(host_sda_oe_n) && dev_sda_oe_n);
   c_scl_pulse: cover property ($rose(module_clock_pin));
endmodule // irs_link_assertions

// *** verif/i2c_register_read_and_sam_link_bench.sv ***
// Bench: the host end reads registers of the device end over the module link.
// Assumes both ends meet in irs_link_if; the bench models the register file.
`timescale 1ns/100ps
`include "irs_map.svh"
module i2c_register_read_and_sam_link_bench;
   logic       clock_in = 0, link_clock = 0, reset_in = 1;
   logic [1:0] nv_bits = 2'h3;
   logic       use_pin = 0, pin = 0, sam_load = 0, cmd_start = 0;
   logic       rd_strobe, busy, rd_valid, nack, done;
   logic [6:0] sam_nv = 7'h00, cmd_addr = 7'h00, sam_addr;
   logic [7:0] cmd_reg = 8'h00, cmd_count = 8'h01, rd_data, rd_addr, host_data;
   logic [7:0] fifo_val = 8'h80, fifo_next = 8'h80, wire_sr = 8'h00;
   int         num_errors = 0, num_checks = 0, cycles = 0;
   localparam logic [6:0] DEV = {`IRS_ADDR_HIGH, 2'h3};

   // ==========================================================
   // Clocks, register file and wire monitor
   always #5 clock_in = ~clock_in;
   initial begin
      #13;
      forever #40 link_clock = ~link_clock;
   end
   // FIFO pops once per strobe, every other place reads as its address mixed
   assign rd_data = (rd_addr == `IRS_FIFO_ADDR) ? fifo_val : rd_addr ^ 8'h5a;
   always @(posedge clock_in) if (rd_strobe && rd_addr == `IRS_FIFO_ADDR) fifo_val <= fifo_val + 8'h01;
   always @(posedge u_irs_link_if.module_clock_pin) begin
      wire_sr <= {wire_sr[6:0], u_irs_link_if.module_data_in_pin};
   end
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         final_report();
      end
   end

   irs_link_if u_irs_link_if ();
   irs_host u_irs_host (.clock_in(clock_in), .reset_in(reset_in), .link(u_irs_link_if.host),
      .cmd_start_in(cmd_start), .cmd_dev_addr_in(cmd_addr), .cmd_reg_in(cmd_reg),
      .cmd_count_in(cmd_count), .busy_out(busy), .rd_data_out(host_data),
      .rd_valid_out(rd_valid), .nack_out(nack), .done_out(done));
   irs_device u_irs_device (.clock_in(clock_in), .reset_in(reset_in), .link_clock_in(link_clock),
      .link(u_irs_link_if.device), .addr_nv_bits_in(nv_bits), .addr_use_pin_in(use_pin),
      .addr_pin_in(pin), .sam_addr_load_in(sam_load), .sam_addr_nv_in(sam_nv),
      .rd_data_in(rd_data), .rd_addr_out(rd_addr), .rd_strobe_out(rd_strobe),
      .sam_addr_out(sam_addr));
   irs_link_assertions u_irs_link_assertions (.clock_in(clock_in), .reset_in(reset_in),
      .module_clock_pin(u_irs_link_if.module_clock_pin), .host_sda_out(u_irs_link_if.host_sda_out),
      .host_sda_oe_n(u_irs_link_if.host_sda_oe_n), .dev_sda_out(u_irs_link_if.dev_sda_out),
      .dev_sda_oe_n(u_irs_link_if.dev_sda_oe_n), .dev_sda_keep(u_irs_link_if.dev_sda_keep),
      .module_data_in_pin(u_irs_link_if.module_data_in_pin));

   // ==========================================================
   // Tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      if (num_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Address write, repeated start, then n bytes read; fail means no ACK expected
   task automatic read_regs(input logic [6:0] addr, input logic [7:0] ra, input int n,
                            input logic fail);
      logic [7:0] exp;
      int         k;
      k = 0;
      @(negedge clock_in);
      cmd_addr = addr;
      cmd_reg = ra;
      cmd_count = n[7:0];
      cmd_start = 1;
      @(negedge clock_in);
      cmd_start = 0;
      for (int c = 0; c < 20000 && done !== 1'b1; c++) begin
         @(negedge clock_in);
         if (rd_valid === 1'b1) begin
            exp = (ra == `IRS_FIFO_ADDR) ? fifo_next : (ra + k[7:0]) ^ 8'h5a;
            fifo_next = fifo_next + {7'h00, ra == `IRS_FIFO_ADDR};
            check(host_data, exp, "read byte");
            check(wire_sr, exp, "wire byte");
            k++;
         end
      end
      check({7'h00, done}, 8'h01, "done");
      check({7'h00, nack}, {7'h00, fail}, "nack");
      check(k[7:0], fail ? 8'h00 : n[7:0], "byte count");
      check({6'h00, busy, u_irs_link_if.dev_sda_oe_n}, 8'h01, "released");
   endtask

   // ==========================================================
   // Tests
   initial begin
      // Link side needs three link edges of reset, so four fast cycles are too few
      repeat (32) @(negedge clock_in);
      reset_in = 0;
      @(negedge clock_in);
      check({1'b0, sam_addr}, {1'b0, `IRS_SAM_ADDR_RST}, "module address");
      check({7'h00, u_irs_link_if.module_data_in_pin}, 8'h01, "idle sda");
      read_regs(DEV, 8'h10, 3, 0);
      read_regs(DEV, `IRS_FIFO_ADDR, 3, 0);
      read_regs(7'h2c, 8'h10, 1, 1);
      nv_bits = 2'h1;
      read_regs({`IRS_ADDR_HIGH, 2'h1}, 8'h30, 1, 0);
      nv_bits = 2'h3;
      use_pin = 1;
      pin = 1;
      read_regs(DEV, 8'h20, 1, 1);
      read_regs({`IRS_ADDR_HIGH, 2'h1}, 8'h20, 2, 0);
      pin = 0;
      read_regs({`IRS_ADDR_HIGH, 2'h0}, 8'h40, 1, 0);
      sam_nv = 7'h33;
      sam_load = 1;
      @(negedge clock_in);
      sam_load = 0;
      @(negedge clock_in);
      check({1'b0, sam_addr}, 8'h33, "module address load");
      final_report();
   end
endmodule // i2c_register_read_and_sam_link_bench
